// File: verilog/csw_clock_switch.sv
// CPU clock switchover control: registers, delayed switch, oscillator gating
//
// Function
// [R01] On subsystem clock, instruction time is fixed; ratio bits are ignored.
// [R02] Watchdog counting is halted while CPU runs from subsystem clock.
// [R03] Software must not enter oscillator-stopping standby on subsystem clock.
// [R04] CPU clock chosen by ratio bits 0-2 and source select bit 4.
// [R05] A written setting takes effect only after some old-clock instructions.
// [R06] Bit 5 reports whether CPU runs on main or subsystem clock.
// [R07] Main ratio switch waits 16,8,4,2,1 instructions; from subsystem waits one.
// [R08] Main to subsystem waits main_osc_freq/(2 sub_osc_freq) instructions, halving per slower step.
// [R09] Software must not change ratio while moving main to subsystem.
// [R10] After reset, main oscillator runs and CPU waits 2^17 main periods.
// [R11] CPU then starts at the slowest main clock setting.
// [R12] Clearing stop bit 7 restarts the main oscillator.
// [R13] Software waits stabilization itself before returning to main clock.
// [R14] Software selects subsystem clock only when it oscillates stably.
// [R15] Software raises speed only after the supply has risen enough.
// [R16] Prescaler bit 0 of oscillation mode sets main rate and switch delays.
// [R17] Reset loads control 04H and oscillation mode 00H.
// [R18] Stop bit stops main oscillator only once CPU is on subsystem clock.
// [R19] Status bit is read-only and changes only when the switch completes.
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
module csw_clock_switch
    import csw_pkg::*;
#(
    parameter int STAB_PERIODS = CSW_STAB_PERIODS
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic main_osc_in,
    input wire logic sub_osc_in,
    output logic main_osc_enable,
    output logic cpu_run,
    output logic cpu_instr_tick,
    output logic cpu_on_sub,
    output logic wdt_count_enable
);

    // ************************************************************
    // Functions
    // ************************************************************
    // Ratio codes above the slowest act as the slowest
    function automatic logic [2:0] clamp_ratio(input logic [2:0] r);
        return (r > CSW_RATIO_SLOWEST) ? CSW_RATIO_SLOWEST : r;
    endfunction

    // Old-clock instructions that a switch from act to the new setting takes
    function automatic logic [7:0] switch_delay(input csw_setting_s act, input logic to_sub,
                                                input logic prescaler_sel);
        logic [7:0] d;
        logic [2:0] steps;
        d = CSW_ONE_INSTR;
        steps = 3'(clamp_ratio(act.ratio) + {2'b00, !prescaler_sel});
        if (act.src_sub) begin
            d = CSW_ONE_INSTR; // see [R07]
        end else if (to_sub) begin
            d = CSW_SUB_SWITCH_BASE; // see [R08]
            for (int i = 0; i < CSW_HALVE_STEPS; i++) begin
                if (3'(i) < steps) begin
                    d = 8'((9'(d) + 9'h001) >> 1); // see [R16]
                end
            end
        end else begin
            d = CSW_MAIN_SWITCH_BASE >> clamp_ratio(act.ratio); // see [R07]
        end
        return d;
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************
    csw_setting_s req_r, act_r, req_nxt;
    csw_state_e state_r;
    logic stop_r, main_prescaler_select_r, on_sub_nxt;
    logic [7:0] dly_r;
    logic [17:0] stab_r;
    logic stab_done_r;
    logic main_s1_r, main_s2_r, main_s3_r, sub_s1_r, sub_s2_r, sub_s3_r;
    logic main_tick, sub_tick, src_tick, instr_tick, apply;
    logic [6:0] period;
    logic bus_req, bus_take, ctrl_wr, mode_wr;

    // ************************************************************
    // Oscillator pin synchronisers
    // ************************************************************
    // Third stage only serves edge detection; first stage feeds nothing else
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            main_s1_r <= 1'b0;
            main_s2_r <= 1'b0;
            main_s3_r <= 1'b0;
            sub_s1_r <= 1'b0;
            sub_s2_r <= 1'b0;
            sub_s3_r <= 1'b0;
        end else begin
            main_s1_r <= main_osc_in;
            main_s2_r <= main_s1_r;
            main_s3_r <= main_s2_r;
            sub_s1_r <= sub_osc_in;
            sub_s2_r <= sub_s1_r;
            sub_s3_r <= sub_s2_r;
        end
    end

    // Rising edges count as oscillator periods; a stopped oscillator gives none
    assign main_tick = main_s2_r && !main_s3_r && main_osc_enable;
    assign sub_tick = sub_s2_r && !sub_s3_r;

    // ************************************************************
    // Avalon-MM slave
    // ************************************************************
    // One wait cycle per access keeps read data registered
    assign bus_req = avs_read ^ avs_write;
    assign bus_take = bus_req && !avs_waitrequest;
    assign ctrl_wr = bus_take && avs_write && avs_byteenable[0] && (avs_address == CSW_ADDR_CTRL);
    assign mode_wr = bus_take && avs_write && avs_byteenable[0] && (avs_address == CSW_ADDR_OSC_MODE);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(bus_req && avs_waitrequest);
        end
    end

    // Unmapped addresses read as zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= 32'h0000_0000;
            if (avs_address == CSW_ADDR_CTRL) begin
                avs_readdata[CSW_RATIO_LSB +: 3] <= req_r.ratio;
                avs_readdata[CSW_SRC_SEL_BIT] <= req_r.src_sub;
                avs_readdata[CSW_STATUS_BIT] <= cpu_on_sub; // see [R06]
                avs_readdata[CSW_STOP_BIT] <= stop_r;
            end else if (avs_address == CSW_ADDR_OSC_MODE) begin
                avs_readdata[CSW_PRESCALER_BIT] <= main_prescaler_select_r;
            end
        end
    end

    // ************************************************************
    // Control and oscillation mode registers
    // ************************************************************
    // Status bit is not writable; it follows the applied setting only
    assign req_nxt = '{ratio: avs_writedata[CSW_RATIO_LSB +: 3], src_sub: avs_writedata[CSW_SRC_SEL_BIT]};

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            req_r <= '{ratio: CSW_CTRL_RESET[CSW_RATIO_LSB +: 3], src_sub: CSW_CTRL_RESET[CSW_SRC_SEL_BIT]};
            stop_r <= CSW_CTRL_RESET[CSW_STOP_BIT]; // see [R17]
        end else if (ctrl_wr) begin
            req_r <= req_nxt; // see [R04]
            stop_r <= avs_writedata[CSW_STOP_BIT];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            main_prescaler_select_r <= CSW_OSC_MODE_RESET[CSW_PRESCALER_BIT]; // see [R17]
        end else if (mode_wr) begin
            main_prescaler_select_r <= avs_writedata[CSW_PRESCALER_BIT]; // see [R16]
        end
    end

    // ************************************************************
    // Stabilization wait after reset
    // ************************************************************
    // Only the reset release is covered; a later restart is left to software
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stab_r <= 18'h00000;
            stab_done_r <= 1'b0;
        end else if (!stab_done_r && main_tick) begin
            stab_r <= stab_r + 18'h00001;
            stab_done_r <= (stab_r + 18'h00001 >= 18'(STAB_PERIODS)); // see [R10]
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cpu_run <= 1'b0;
        end else begin
            cpu_run <= stab_done_r; // see [R10]
        end
    end

    // ************************************************************
    // Instruction timing
    // ************************************************************
    // Main: 2 prescaled periods per instruction, doubling per ratio step; prescaler 0 halves the rate
    assign period = act_r.src_sub ? CSW_SUB_TICKS_PER_INSTR // see [R01]
                                  : 7'(CSW_MAIN_TICKS_BASE << clamp_ratio(act_r.ratio)) << !main_prescaler_select_r;
    assign src_tick = act_r.src_sub ? sub_tick : main_tick;

    csw_instr_timer u_instr_timer (
        .mclk(mclk),
        .rst(rst),
        .run(cpu_run),
        .src_tick(src_tick),
        .period(period),
        .instr_tick(instr_tick)
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cpu_instr_tick <= 1'b0;
        end else begin
            cpu_instr_tick <= instr_tick;
        end
    end

    // ************************************************************
    // Delayed switchover
    // ************************************************************
    // A new write restarts the wait, measured from the clock still in use
    assign apply = (state_r == ST_WAIT) && instr_tick && (dly_r == CSW_ONE_INSTR);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            dly_r <= CSW_ONE_INSTR;
        end else if (ctrl_wr && (req_nxt != act_r)) begin
            state_r <= ST_WAIT; // see [R05]
            dly_r <= switch_delay(act_r, req_nxt.src_sub && !act_r.src_sub, main_prescaler_select_r);
        end else if (apply) begin
            state_r <= ST_IDLE;
        end else if ((state_r == ST_WAIT) && instr_tick) begin
            dly_r <= dly_r - 8'h01;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            act_r <= '{ratio: CSW_RATIO_SLOWEST, src_sub: 1'b0}; // see [R11]
        end else if (apply) begin
            act_r <= req_r; // see [R05]
        end
    end

    // ************************************************************
    // Status, watchdog and oscillator gating outputs
    // ************************************************************
    assign on_sub_nxt = apply ? req_r.src_sub : act_r.src_sub;

    // Main oscillator stops only once the CPU has really left it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cpu_on_sub <= 1'b0;
            wdt_count_enable <= 1'b1;
            main_osc_enable <= 1'b1;
        end else begin
            cpu_on_sub <= on_sub_nxt; // see [R19]
            wdt_count_enable <= !on_sub_nxt; // see [R02]
            main_osc_enable <= !(on_sub_nxt && (ctrl_wr ? avs_writedata[CSW_STOP_BIT] : stop_r)); // see [R18] [R12]
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic [7:0] seen_r, max_r;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            seen_r <= 8'h00;
            max_r <= 8'h00;
        end else if (ctrl_wr && (req_nxt != act_r)) begin
            seen_r <= 8'h00;
            max_r <= switch_delay(act_r, req_nxt.src_sub && !act_r.src_sub, main_prescaler_select_r);
        end else if (instr_tick && (seen_r != 8'hFF)) begin
            seen_r <= seen_r + 8'h01;
        end
    end

    sequence switch_done_s;
        apply ##1 (cpu_on_sub == $past(req_r.src_sub));
    endsequence

    wdt_gate_a: assert property (cpu_on_sub |-> !wdt_count_enable) // see [R02]
        else $error("watchdog counts on subsystem clock");
    osc_keep_a: assert property (!cpu_on_sub |-> main_osc_enable) // see [R18]
        else $error("main oscillator stopped while CPU uses it");
    osc_restart_a: assert property (!stop_r && !ctrl_wr |=> main_osc_enable) // see [R12]
        else $error("main oscillator not running with stop bit clear");
    stab_hold_a: assert property (!stab_done_r |=> !cpu_run) // see [R10]
        else $error("CPU runs before stabilization");
    start_slow_a: assert property ($rose(cpu_run) |-> !cpu_on_sub && act_r.ratio == CSW_RATIO_SLOWEST) // see [R11]
        else $error("CPU did not start at slowest setting");
    sub_period_a: assert property (act_r.src_sub |-> period == CSW_SUB_TICKS_PER_INSTR) // see [R01]
        else $error("subsystem instruction time depends on ratio");
    status_hold_a: assert property (!apply |=> $stable(cpu_on_sub)) // see [R19]
        else $error("status changed without completed switch");
    status_done_a: assert property (apply |-> switch_done_s) // see [R06]
        else $error("status does not follow completed switch");
    delay_bound_a: assert property (apply |-> seen_r < max_r) // see [R07]
        else $error("switch took more instructions than allowed");

endmodule

// File: common/csw_pkg.sv
// Package: constants, types and register map of the CPU clock switchover block
package csw_pkg;

    // ************************************************************
    // Register map (byte addresses, one word each)
    // ************************************************************
    localparam logic [2:0] CSW_ADDR_CTRL = 3'h0;
    localparam logic [2:0] CSW_ADDR_OSC_MODE = 3'h4;

    // Processor clock control field positions
    localparam int CSW_RATIO_LSB = 0;
    localparam int CSW_SRC_SEL_BIT = 4;
    localparam int CSW_STATUS_BIT = 5;
    localparam int CSW_STOP_BIT = 7;
    // Oscillation mode field position
    localparam int CSW_PRESCALER_BIT = 0;

    // Reset values
    localparam logic [7:0] CSW_CTRL_RESET = 8'h04;
    localparam logic [7:0] CSW_OSC_MODE_RESET = 8'h00;
    localparam logic [2:0] CSW_RATIO_SLOWEST = 3'h4;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CSW_MAIN_OSC_HZ = 5_000_000;
    localparam int CSW_SUB_OSC_HZ = 32_768;
    // Old-clock instructions for main to subsystem at fastest setting
    localparam logic [7:0] CSW_SUB_SWITCH_BASE =
        8'((CSW_MAIN_OSC_HZ + 2 * CSW_SUB_OSC_HZ - 1) / (2 * CSW_SUB_OSC_HZ));
    localparam logic [7:0] CSW_MAIN_SWITCH_BASE = 8'h10;
    localparam logic [7:0] CSW_ONE_INSTR = 8'h01;
    // Subsystem ticks per instruction (122 us at 32.768 kHz)
    localparam logic [6:0] CSW_SUB_TICKS_PER_INSTR = 7'h04;
    // Main ticks per instruction at ratio 000 with full-rate prescaler
    localparam logic [6:0] CSW_MAIN_TICKS_BASE = 7'h02;
    localparam int CSW_STAB_PERIODS = 2 ** 17;
    localparam int CSW_HALVE_STEPS = 5;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic [2:0] ratio;
        logic src_sub;
    } csw_setting_s;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } csw_state_e;

endpackage

// File: verilog/csw_instr_timer.sv
// Instruction timer: one pulse per instruction time of the active source
`timescale 1ns/1ns
module csw_instr_timer
    import csw_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    input wire logic src_tick,
    input wire logic [6:0] period,
    output logic instr_tick
);

    logic [6:0] cnt_r;

    // ************************************************************
    // Tick counter
    // ************************************************************
    // A period that shrinks mid-count wraps on the next source tick instead of overrunning
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r <= 7'h00;
            instr_tick <= 1'b0;
        end else if (!run) begin
            cnt_r <= 7'h00;
            instr_tick <= 1'b0;
        end else if (src_tick && (cnt_r + 7'h01 >= period)) begin
            cnt_r <= 7'h00;
            instr_tick <= 1'b1;
        end else begin
            cnt_r <= src_tick ? cnt_r + 7'h01 : cnt_r;
            instr_tick <= 1'b0;
        end
    end

endmodule

// File: verif/cpu_clock_switchover_control_bench.sv
// Self-checking bench for the CPU clock switchover block
`timescale 1ns/1ns
module cpu_clock_switchover_control_bench
    import csw_pkg::*;
;
    // ************************************************************
    // Stimulus signals and bench state
    // ************************************************************
    localparam int MH = 5;
    localparam int SH = 20;
    localparam int LIMIT = 100000;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic main_osc_in = 1'b0;
    logic sub_osc_in = 1'b0;
    logic main_osc_enable, cpu_run, cpu_instr_tick, cpu_on_sub, wdt_count_enable;
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    int medges = 0;
    int mcnt = 0;
    int scnt = 0;
    int g, n, r, r2, cur, k, s;
    logic [31:0] d;

    // Short stabilization count keeps the run brief
    csw_clock_switch #(.STAB_PERIODS(16)) dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .main_osc_in(main_osc_in), .sub_osc_in(sub_osc_in), .main_osc_enable(main_osc_enable),
        .cpu_run(cpu_run), .cpu_instr_tick(cpu_instr_tick), .cpu_on_sub(cpu_on_sub),
        .wdt_count_enable(wdt_count_enable));

    always #10 mclk = ~mclk;

    // Oscillators; the main one really stops when its enable drops
    // Subsystem oscillator runs stably from time zero
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        mcnt <= (mcnt == MH - 1) ? 0 : mcnt + 1;
        scnt <= (scnt == SH - 1) ? 0 : scnt + 1;
        if (mcnt == MH - 1 && main_osc_enable === 1'b1) begin
            main_osc_in <= ~main_osc_in;
        end
        if (scnt == SH - 1) begin
            sub_osc_in <= ~sub_osc_in;
        end
        if (cyc >= LIMIT) begin
            errors++;
            conclude();
        end
    end

    // Main edges seen since reset release
    always @(posedge main_osc_in) begin
        if (!rst) begin
            medges++;
        end
    end

    // ************************************************************
    // Model and helpers
    // ************************************************************
    function automatic int per(int rr, int psc, int sub);
        if (sub != 0) return 4 * 2 * SH;
        if (rr > 4) rr = 4;
        return (2 << rr) * ((psc != 0) ? 1 : 2) * 2 * MH;
    endfunction

    // Main to subsystem delay: 77 halved, rounding up, per slower step
    function automatic int sdly(int rr, int psc);
        int v;
        v = 77;
        if (rr > 4) rr = 4;
        repeat (rr + ((psc != 0) ? 0 : 1)) v = (v + 1) / 2;
        return v;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Bus cycles: one edge passes first so a strobe is never set twice in a step
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'h0, v};
        avs_write <= 1'b1;
        @(posedge mclk iff avs_waitrequest === 1'b0);
        avs_write <= 1'b0;
    endtask

    task automatic bus_rd(input logic [2:0] a, output logic [31:0] v);
        @(posedge mclk);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge mclk iff avs_waitrequest === 1'b0);
        v = avs_readdata;
        avs_read <= 1'b0;
    endtask

    task automatic skip_ticks(input int cnt);
        repeat (cnt) @(posedge mclk iff cpu_instr_tick === 1'b1);
    endtask

    task automatic tick_gap(output int gg);
        int t0;
        @(posedge mclk iff cpu_instr_tick === 1'b1);
        t0 = cyc;
        @(posedge mclk iff cpu_instr_tick === 1'b1);
        gg = cyc - t0;
    endtask

    // Ticks counted until the status output reaches lvl
    // The tick that completes a switch shows together with the status, so it counts first
    task automatic count_to(input logic lvl, output int cnt);
        cnt = 0;
        for (int t = 0; t < 20000; t++) begin
            @(posedge mclk);
            if (cpu_instr_tick === 1'b1) cnt++;
            if (cpu_on_sub === lvl) break;
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        r = $urandom(36009);
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk iff cpu_run === 1'b1);
        check(32'(medges >= 16 && medges <= 17), 32'h1);
        bus_rd(CSW_ADDR_CTRL, d);
        check(d, 32'h04);
        bus_rd(CSW_ADDR_OSC_MODE, d);
        check(d, 32'h00);
        bus_rd(3'h2, d);
        check(d, 32'h00);
        // Lane 0 disabled: the write must leave the control register alone
        avs_byteenable <= 4'h0;
        bus_wr(CSW_ADDR_CTRL, 8'h83);
        avs_byteenable <= 4'h1;
        bus_rd(CSW_ADDR_CTRL, d);
        check(d, 32'h04);
        tick_gap(g);
        check(g, per(4, 0, 0));
        bus_wr(CSW_ADDR_OSC_MODE, 8'h01); // supply taken as already up
        skip_ticks(2);
        tick_gap(g);
        check(g, per(4, 1, 0));
        // Ratio walk: old clock holds for 16>>old ticks, then new period
        cur = 4;
        for (int i = 0; i < 4; i++) begin
            r = $urandom % 5;
            if (r == cur) r = (cur + 1) % 5;
            bus_wr(CSW_ADDR_CTRL, 8'(r));
            if (cur <= 2) begin
                tick_gap(g);
                check(g, per(cur, 1, 0));
                skip_ticks((16 >> cur) - 1);
            end else begin
                skip_ticks((16 >> cur) + 1);
            end
            tick_gap(g);
            check(g, per(r, 1, 0));
            bus_rd(CSW_ADDR_CTRL, d);
            check(d, 32'(r));
            cur = r;
        end
        // Two trips to the subsystem clock, second one with oscillator stop
        // No standby entry is ever made while on the subsystem clock
        for (k = 0; k < 2; k++) begin
            s = (k == 1) ? 8'h80 : 8'h00;
            bus_wr(CSW_ADDR_OSC_MODE, 8'(1 - k));
            r = $urandom % 5;
            bus_wr(CSW_ADDR_CTRL, 8'(s | r));
            skip_ticks(17);
            check(main_osc_enable, 32'h1);
            bus_wr(CSW_ADDR_CTRL, 8'(s | 8'h10 | r)); // ratio kept
            count_to(1'b1, n);
            check(n, sdly(r, 1 - k));
            @(posedge mclk);
            check(cpu_on_sub, 32'h1);
            check(wdt_count_enable, 32'h0);
            check(main_osc_enable, 32'(k == 0));
            bus_rd(CSW_ADDR_CTRL, d);
            check(d, 32'(s | 8'h30 | r));
            r2 = (r + 1) % 5;
            bus_wr(CSW_ADDR_CTRL, 8'(8'h10 | r2));
            repeat (2) @(posedge mclk);
            check(main_osc_enable, 32'h1);
            skip_ticks(2);
            tick_gap(g);
            check(g, per(0, 0, 1));
            repeat (200) @(posedge mclk); // stabilization wait
            bus_wr(CSW_ADDR_CTRL, 8'(8'h20 | r2));
            count_to(1'b0, n);
            check(n, 32'h1);
            @(posedge mclk);
            check(cpu_on_sub, 32'h0);
            check(wdt_count_enable, 32'h1);
            bus_rd(CSW_ADDR_CTRL, d);
            check(d, 32'(r2));
        end
        conclude();
    end
endmodule
